// ---- flc_pkg.sv ----
package flc_pkg;

   // ---------------------------------------------------------------
   // Clock and flash bus timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 4000;
   localparam int T_SETUP_NS    = 10;
   localparam int T_STROBE_NS   = 70;
   localparam int T_HOLD_NS     = 20;
   // Least times, so round up
   localparam int SETUP_CYC  = (T_SETUP_NS * 1000 + CLK_PERIOD_PS - 1)
                               / CLK_PERIOD_PS;
   localparam int STROBE_CYC = (T_STROBE_NS * 1000 + CLK_PERIOD_PS - 1)
                               / CLK_PERIOD_PS;
   localparam int HOLD_CYC   = (T_HOLD_NS * 1000 + CLK_PERIOD_PS - 1)
                               / CLK_PERIOD_PS;
   localparam logic [7:0] SETUP_CNT  = 8'(SETUP_CYC);
   localparam logic [7:0] STROBE_CNT = 8'(STROBE_CYC);
   localparam logic [7:0] HOLD_CNT   = 8'(HOLD_CYC);

   localparam int ADDR_W = 22;
   localparam int DATA_W = 16;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_CMD    = 8'h00;
   localparam logic [7:0] OFS_ADDR   = 8'h04;
   localparam logic [7:0] OFS_WDATA  = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0C;
   localparam logic [7:0] OFS_CTRL   = 8'h10;
   localparam int STAT_BUSY      = 0;
   localparam int STAT_DONE      = 1;
   localparam int STAT_RDATA_LSB = 16;
   localparam int CTRL_WP        = 0;
   localparam int CTRL_RUN       = 1;
   localparam logic [1:0] CTRL_RESET = 2'h0;

   // ---------------------------------------------------------------
   // Flash command codes and addresses
   // ---------------------------------------------------------------
   localparam logic [15:0] CODE_LOCK_SETUP = 16'h0060;
   localparam logic [15:0] CODE_LOCK_CONF  = 16'h0001;
   localparam logic [15:0] CODE_UNLOCK     = 16'h00D0;
   localparam logic [15:0] CODE_LOCKDOWN   = 16'h002F;
   localparam logic [15:0] CODE_READ_ID    = 16'h0090;
   localparam logic [15:0] CODE_READ_ARRAY = 16'h00FF;
   localparam logic [15:0] CODE_PROT_SETUP = 16'h00C0;
   localparam logic [15:0] CODE_PROT_LOCK  = 16'hFFFD;
   localparam logic [15:0] CODE_SUSPEND    = 16'h00B0;
   localparam logic [15:0] CODE_RESUME     = 16'h00D0;
   localparam logic [15:0] CODE_READ_STAT  = 16'h0070;
   localparam logic [21:0] LOCK_ID_OFS     = 22'h000002;
   localparam logic [21:0] PROTECTION_LOCK_WORD_ADDR    = 22'h000080;
   localparam logic [7:0]  MASK_READY      = 8'h80;
   localparam logic [7:0]  MASK_SUSPENDED  = 8'hC0;

   typedef enum logic [3:0] {
      OP_LOCK        = 4'h0,
      OP_UNLOCK      = 4'h1,
      OP_LOCKDOWN    = 4'h2,
      OP_READ_LOCK   = 4'h3,
      OP_PR_READ     = 4'h4,
      OP_PR_PROG     = 4'h5,
      OP_PROTECTION_LOCK_WORD     = 4'h6,
      OP_SUSPEND     = 4'h7,
      OP_RESUME      = 4'h8,
      OP_READ_STATUS = 4'h9,
      OP_READ_ARRAY  = 4'hA
   } flc_op_t;
   localparam logic [3:0] OP_LAST = 4'hA;

   // asel: 0 = base address, 1 = base + 2, 2 = protection lock word
   typedef struct packed {
      logic        last;
      logic        rd;
      logic [7:0]  mask;
      logic [1:0]  asel;
      logic [15:0] data;
   } flc_step_t;

endpackage

// ---- flc_cyc_if.sv ----
`timescale 1ns/100ps
interface flc_cyc_if;
   import flc_pkg::*;
   logic              req;
   logic              rd;
   logic              done;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic [DATA_W-1:0] rdata;
   modport seq (output req, rd, addr, wdata, input done, rdata);
   modport eng (input req, rd, addr, wdata, output done, rdata);
endinterface

// ---- flc_cycle.sv ----
`timescale 1ns/100ps
module flc_cycle
   import flc_pkg::*;
(
   // Clock and reset
   input  wire logic              ref_clk,
   input  wire logic              rst_sync_n,
   // Cycle request
   flc_cyc_if.eng                 cyc,
   // Flash pins
   output logic [ADDR_W-1:0]      flash_addr,
   input  wire logic [DATA_W-1:0] flash_dq_in,
   output logic [DATA_W-1:0]      flash_dq_out,
   output logic                   flash_dq_oe,
   output logic                   flash_ce_n,
   output logic                   flash_oe_n,
   output logic                   flash_we_n
);

   typedef enum logic [3:0] {
      E_IDLE   = 4'b0001,
      E_SETUP  = 4'b0010,
      E_STROBE = 4'b0100,
      E_HOLD   = 4'b1000
   } flc_eng_t;

   flc_eng_t   state;
   logic [7:0] cnt;
   logic       rd_q;
   wire        cnt_end = (cnt == 8'h01);

   // ---------------------------------------------------------------
   // One bus cycle: setup, strobe, hold
   // ---------------------------------------------------------------
   // Data is sampled at the last strobe cycle, the widest valid window
   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         state        <= E_IDLE;
         cnt          <= 8'h00;
         rd_q         <= 1'b0;
         cyc.done     <= 1'b0;
         cyc.rdata    <= 16'h0000;
         flash_addr   <= 22'h000000;
         flash_dq_out <= 16'h0000;
         flash_dq_oe  <= 1'b0;
         flash_ce_n   <= 1'b1;
         flash_oe_n   <= 1'b1;
         flash_we_n   <= 1'b1;
      end else begin
         cyc.done <= 1'b0;
         case (state)
            E_IDLE: if (cyc.req) begin
               rd_q         <= cyc.rd;
               flash_addr   <= cyc.addr;
               flash_dq_out <= cyc.wdata;
               flash_dq_oe  <= !cyc.rd;
               flash_ce_n   <= 1'b0;
               cnt          <= SETUP_CNT;
               state        <= E_SETUP;
            end
            E_SETUP: if (cnt_end) begin
               flash_oe_n <= !rd_q;
               flash_we_n <= rd_q;
               cnt        <= STROBE_CNT;
               state      <= E_STROBE;
            end else begin
               cnt <= cnt - 8'h01;
            end
            E_STROBE: if (cnt_end) begin
               if (rd_q) begin
                  cyc.rdata <= flash_dq_in;
               end
               flash_oe_n <= 1'b1;
               flash_we_n <= 1'b1;
               cnt        <= HOLD_CNT;
               state      <= E_HOLD;
            end else begin
               cnt <= cnt - 8'h01;
            end
            E_HOLD: if (cnt_end) begin
               flash_ce_n  <= 1'b1;
               flash_dq_oe <= 1'b0;
               cyc.done    <= 1'b1;
               state       <= E_IDLE;
            end else begin
               cnt <= cnt - 8'h01;
            end
            default: state <= E_IDLE;
         endcase
      end
   end

endmodule // flc_cycle

// ---- flc_host.sv ----
`timescale 1ns/100ps
module flc_host
   import flc_pkg::*;
(
   // Clock and reset
   input  wire logic              ref_clk,
   input  wire logic              rst_n,
   // APB slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   // Flash pins
   output logic [ADDR_W-1:0]      flash_addr,
   input  wire logic [DATA_W-1:0] flash_dq_in,
   output logic [DATA_W-1:0]      flash_dq_out,
   output logic                   flash_dq_oe,
   output logic                   flash_ce_n,
   output logic                   flash_oe_n,
   output logic                   flash_we_n,
   output logic                   write_protect_pin,
   output logic                   reset_powerdown_pin_n
);

   typedef enum logic [2:0] {
      S_IDLE  = 3'b001,
      S_ISSUE = 3'b010,
      S_WAIT  = 3'b100
   } flc_seq_t;

   // ---------------------------------------------------------------
   // Reset release
   // ---------------------------------------------------------------
   logic rst_meta_n;
   logic rst_sync_n;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_n <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta_n <= 1'b1;
         rst_sync_n <= rst_meta_n;
      end
   end

   // ---------------------------------------------------------------
   // Command step table
   // ---------------------------------------------------------------
   function automatic flc_step_t mk(input logic l, input logic r,
                                    input logic [7:0] m,
                                    input logic [1:0] a,
                                    input logic [15:0] d);
      mk = '{last: l, rd: r, mask: m, asel: a, data: d};
   endfunction

   function automatic flc_step_t step_of(input logic [3:0] op,
                                         input logic [1:0] idx,
                                         input logic [15:0] wd);
      flc_step_t s;
      s = mk(1'b1, 1'b0, 8'h00, 2'h0, CODE_READ_ARRAY);
      case (op)
         OP_LOCK:
            s = (idx == 2'h0) ? mk(1'b0, 1'b0, 8'h00, 2'h0, CODE_LOCK_SETUP)
                              : mk(1'b1, 1'b0, 8'h00, 2'h0, CODE_LOCK_CONF);
         OP_UNLOCK:
            s = (idx == 2'h0) ? mk(1'b0, 1'b0, 8'h00, 2'h0, CODE_LOCK_SETUP)
                              : mk(1'b1, 1'b0, 8'h00, 2'h0, CODE_UNLOCK);
         OP_LOCKDOWN:
            s = (idx == 2'h0) ? mk(1'b0, 1'b0, 8'h00, 2'h0, CODE_LOCK_SETUP)
                              : mk(1'b1, 1'b0, 8'h00, 2'h0, CODE_LOCKDOWN);
         OP_READ_LOCK, OP_PR_READ: begin
            case (idx)
               2'h0:    s = mk(1'b0, 1'b0, 8'h00, 2'h0, CODE_READ_ID);
               2'h1:    s = mk(1'b0, 1'b1, 8'h00,
                               (op == OP_READ_LOCK) ? 2'h1 : 2'h0, 16'h0000);
               default: s = mk(1'b1, 1'b0, 8'h00, 2'h0, CODE_READ_ARRAY);
            endcase
         end
         OP_PR_PROG, OP_PROTECTION_LOCK_WORD: begin
            case (idx)
               2'h0: s = mk(1'b0, 1'b0, 8'h00,
                            (op == OP_PROTECTION_LOCK_WORD) ? 2'h2 : 2'h0, CODE_PROT_SETUP);
               2'h1: s = mk(1'b0, 1'b0, 8'h00,
                            (op == OP_PROTECTION_LOCK_WORD) ? 2'h2 : 2'h0,
                            (op == OP_PROTECTION_LOCK_WORD) ? CODE_PROT_LOCK : wd);
               2'h2:    s = mk(1'b0, 1'b0, 8'h00, 2'h0, CODE_READ_STAT);
               default: s = mk(1'b1, 1'b1, MASK_READY, 2'h0, 16'h0000);
            endcase
         end
         OP_SUSPEND: begin
            case (idx)
               2'h0:    s = mk(1'b0, 1'b0, 8'h00, 2'h0, CODE_SUSPEND);
               2'h1:    s = mk(1'b0, 1'b0, 8'h00, 2'h0, CODE_READ_STAT);
               default: s = mk(1'b1, 1'b1, MASK_SUSPENDED, 2'h0, 16'h0000);
            endcase
         end
         OP_RESUME:
            s = mk(1'b1, 1'b0, 8'h00, 2'h0, CODE_RESUME);
         OP_READ_STATUS:
            s = (idx == 2'h0) ? mk(1'b0, 1'b0, 8'h00, 2'h0, CODE_READ_STAT)
                              : mk(1'b1, 1'b1, 8'h00, 2'h0, 16'h0000);
         default: s = mk(1'b1, 1'b0, 8'h00, 2'h0, CODE_READ_ARRAY);
      endcase
      step_of = s;
   endfunction

   // ---------------------------------------------------------------
   // Registers and decode
   // ---------------------------------------------------------------
   flc_seq_t          state;
   logic [3:0]        op_q;
   logic [1:0]        idx;
   logic [ADDR_W-1:0] addr_reg;
   logic [15:0]       wdata_reg;
   logic [15:0]       rdata_last;
   logic [1:0]        ctrl;
   logic              done_flag;
   logic              done_q;
   logic [15:0]       prev_wr;
   flc_step_t         cur;
   flc_cyc_if         cyc ();

   wire wr_acc    = psel && penable && pwrite;
   wire sel_cmd   = (paddr == OFS_CMD);
   wire sel_addr  = (paddr == OFS_ADDR);
   wire sel_wdata = (paddr == OFS_WDATA);
   wire sel_stat  = (paddr == OFS_STATUS);
   wire sel_ctrl  = (paddr == OFS_CTRL);
   wire mapped    = sel_cmd || sel_addr || sel_wdata || sel_stat || sel_ctrl;
   wire busy      = (state != S_IDLE);
   // Orders are refused while busy so a sequence is never split
   wire cmd_bad   = sel_cmd && pwrite && (busy || pwdata[3:0] > OP_LAST);
   wire cmd_go    = wr_acc && sel_cmd && !cmd_bad;
   wire poll_miss = (cyc.rdata[7:0] & cur.mask) != cur.mask;
   wire [31:0] stat_word = {rdata_last, 14'h0000, done_flag, busy};

   assign pready  = 1'b1;
   assign pslverr = psel && penable && (!mapped || cmd_bad);
   assign prdata  = !(psel && !pwrite) ? 32'h0000_0000 :
                    sel_addr  ? {10'h000, addr_reg} :
                    sel_wdata ? {16'h0000, wdata_reg} :
                    sel_stat  ? stat_word :
                    sel_ctrl  ? {30'h0000_0000, ctrl} : 32'h0000_0000;

   assign cur       = step_of(op_q, idx, wdata_reg);
   assign cyc.req   = (state == S_ISSUE);
   assign cyc.rd    = cur.rd;
   assign cyc.wdata = cur.data;
   assign cyc.addr  = (cur.asel == 2'h1) ? addr_reg + LOCK_ID_OFS :
                      (cur.asel == 2'h2) ? PROTECTION_LOCK_WORD_ADDR : addr_reg;

   // Device stays in reset until software sets CTRL_RUN; the pin level is never sampled here
   assign write_protect_pin     = ctrl[CTRL_WP];
   assign reset_powerdown_pin_n = ctrl[CTRL_RUN];

   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         addr_reg  <= 22'h000000;
         wdata_reg <= 16'h0000;
         ctrl      <= CTRL_RESET;
      end else if (wr_acc) begin
         if (sel_addr)  addr_reg  <= pwdata[ADDR_W-1:0];
         if (sel_wdata) wdata_reg <= pwdata[15:0];
         if (sel_ctrl)  ctrl      <= pwdata[1:0];
      end
   end

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         state      <= S_IDLE;
         op_q       <= 4'h0;
         idx        <= 2'h0;
         rdata_last <= 16'h0000;
         done_flag  <= 1'b0;
         prev_wr    <= 16'h0000;
         done_q     <= 1'b0;
      end else begin
         if (cyc.req && !cur.rd) prev_wr <= cur.data;
         done_q <= done_flag;
         case (state)
            S_IDLE: if (cmd_go) begin
               op_q      <= pwdata[3:0];
               idx       <= 2'h0;
               done_flag <= 1'b0;
               state     <= S_ISSUE;
            end
            S_ISSUE: state <= S_WAIT;
            S_WAIT: if (cyc.done) begin
               if (cur.rd) rdata_last <= cyc.rdata;
               if (cur.rd && poll_miss) begin
                  state <= S_ISSUE;
               end else if (cur.last) begin
                  done_flag <= 1'b1;
                  state     <= S_IDLE;
               end else begin
                  idx   <= idx + 2'h1;
                  state <= S_ISSUE;
               end
            end
            default: state <= S_IDLE;
         endcase
      end
   end

   flc_cycle u_cycle (
      .ref_clk      (ref_clk),
      .rst_sync_n   (rst_sync_n),
      .cyc          (cyc.eng),
      .flash_addr   (flash_addr),
      .flash_dq_in  (flash_dq_in),
      .flash_dq_out (flash_dq_out),
      .flash_dq_oe  (flash_dq_oe),
      .flash_ce_n   (flash_ce_n),
      .flash_oe_n   (flash_oe_n),
      .flash_we_n   (flash_we_n)
   );

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_sync_n);
   wire launch_wr = cyc.req && !cur.rd;
   wire finished  = done_flag && !done_q;

   a_lock_confirm: assert property (
      launch_wr && op_q == OP_LOCK && idx == 2'h1
      |-> cur.data == CODE_LOCK_CONF && prev_wr == CODE_LOCK_SETUP)
      else $error("lock confirm not after setup");
   a_unlock_confirm: assert property (
      launch_wr && op_q == OP_UNLOCK && idx == 2'h1
      |-> cur.data == CODE_UNLOCK && prev_wr == CODE_LOCK_SETUP)
      else $error("unlock confirm not after setup");
   a_lockdown_confirm: assert property (
      launch_wr && op_q == OP_LOCKDOWN && idx == 2'h1
      |-> cur.data == CODE_LOCKDOWN && prev_wr == CODE_LOCK_SETUP)
      else $error("lock-down confirm not after setup");
   a_lock_id_read: assert property (
      cyc.req && cur.rd && op_q == OP_READ_LOCK
      |-> cyc.addr == addr_reg + LOCK_ID_OFS && prev_wr == CODE_READ_ID)
      else $error("lock status read at wrong place or mode");
   a_suspend_seen: assert property (
      finished && op_q == OP_SUSPEND
      |-> rdata_last[7] && rdata_last[6])
      else $error("suspend ended without confirmation");
   a_id_exit: assert property (
      finished && (op_q == OP_PR_READ || op_q == OP_READ_LOCK)
      |-> prev_wr == CODE_READ_ARRAY)
      else $error("identifier mode not left");
   a_prot_word: assert property (
      launch_wr && op_q == OP_PR_PROG && idx == 2'h1
      |-> prev_wr == CODE_PROT_SETUP && cur.data == wdata_reg
          ##1 (state == S_WAIT)[*2])
      else $error("protection word not after setup");
   a_prot_lock: assert property (
      launch_wr && op_q == OP_PROTECTION_LOCK_WORD && idx == 2'h1
      |-> cur.data == CODE_PROT_LOCK && cyc.addr == PROTECTION_LOCK_WORD_ADDR)
      else $error("protection lock value or place wrong");

   c_lockdown: cover property (finished && op_q == OP_LOCKDOWN);
   c_suspend:  cover property (finished && op_q == OP_SUSPEND);
   c_protection_lock_word:  cover property (finished && op_q == OP_PROTECTION_LOCK_WORD);
   c_lock_rd:  cover property (finished && op_q == OP_READ_LOCK);

endmodule // flc_host

// ---- flc_flash_model.sv ----
`timescale 1ns/100ps
module flc_flash_model
   import flc_pkg::*;
(
   // Bus from the controller
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [DATA_W-1:0] dq_drv,
   input  wire logic              ce_n,
   input  wire logic              oe_n,
   input  wire logic              we_n,
   // Protection and reset pins
   input  wire logic              wp,
   input  wire logic              rp_n,
   // Data back to the controller
   output logic      [DATA_W-1:0] dq_in
);
   // ---------------------------------------------------------------
   // Device state
   // ---------------------------------------------------------------
   logic [7:0]  lock;
   logic [7:0]  ldn;
   logic [7:0]  sr;
   logic [1:0]  mode;
   logic [1:0]  pend;
   logic [15:0] last;
   logic [15:0] pr [0:8];
   wire  [2:0]  blk   = addr[17:15];
   wire  [3:0]  pidx  = addr[3:0];
   wire         in_pr = addr[21:4] == 18'h8 && pidx <= 4'h8;
   wire         held  = ldn[blk] && !wp;
   // Factory half never opens; user half follows lock word bit 1
   wire         pr_bad = !in_pr || pidx inside {[4'h1:4'h4]}
                         || !pr[0][1];
   initial begin
      last = 16'h0000;
      pr[0] = 16'hFFFE;
      for (int i = 1; i < 9; i++) begin
         pr[i] = (i < 5) ? 16'h5AC3 : 16'hFFFF;  // Arbitrary factory value
      end
   end
   always @(posedge we_n or negedge rp_n) begin
      if (!rp_n) begin
         lock = 8'hFF;
         ldn = 8'h00;
         sr = 8'h80;
         mode = 2'd0;
         pend = 2'd0;
      end else if (!ce_n && pend == 2'd1) begin
         pend = 2'd0;
         mode = 2'd2;
         case (dq_drv)
            CODE_LOCK_CONF: lock[blk] = 1'b1;
            CODE_UNLOCK: lock[blk] = held;
            CODE_LOCKDOWN: begin
               lock[blk] = 1'b1;
               ldn[blk] = 1'b1;
            end
            default: sr = sr | 8'h30;
         endcase
      end else if (!ce_n && pend == 2'd2) begin
         pend = 2'd0;
         mode = 2'd2;
         if (pr_bad)
            sr = sr | 8'h12;
         else
            pr[pidx] = pr[pidx] & dq_drv;
      end else if (!ce_n) begin
         case (dq_drv)
            CODE_LOCK_SETUP: pend = 2'd1;
            CODE_PROT_SETUP: pend = 2'd2;
            CODE_READ_ID: mode = 2'd1;
            CODE_READ_ARRAY: mode = 2'd0;
            CODE_READ_STAT: mode = 2'd2;
            // Only erase suspend exists here, so locks stay open
            CODE_SUSPEND: sr = sr | 8'h40;
            // Error bits survive the resume on purpose
            CODE_RESUME: sr = sr & 8'hBF;
            default: ;
         endcase
      end
   end
   // Lock-down bites again the moment write-protect drops
   always @(negedge wp) begin
      lock = lock | ldn;
   end
   wire [15:0] lk_word = {14'h0, ldn[blk], lock[blk]};
   wire [15:0] rd_val  = (mode == 2'd2) ? {8'h00, sr} :
                         (mode == 2'd0) ? 16'hFFFF :
                         in_pr ? pr[pidx] : lk_word;
   // Released bus shows the inverse of the last word, never a hold
   assign dq_in = (!ce_n && !oe_n && rp_n) ? rd_val : ~last;
   always @(posedge oe_n) begin
      last = rd_val;
   end
endmodule // flc_flash_model

// ---- flc_host_tb.sv ----
`timescale 1ns/100ps
module flc_host_tb
   import flc_pkg::*;
;
   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   localparam logic [21:0] BLK1 = 22'h008000;
   localparam logic [21:0] BLK2 = 22'h010000;
   localparam logic [21:0] PRU  = 22'h000085;
   logic              ref_clk, rst_n, psel, penable, pwrite, pready;
   logic              pslverr, err, f_oe, f_ce_n, f_oe_n, f_we_n, wp, rp_n;
   logic [7:0]        paddr;
   logic [31:0]       pwdata, prdata, rdv;
   logic [ADDR_W-1:0] f_addr;
   logic [DATA_W-1:0] f_din, f_dout;
   int                fails = 0;
   int                cmp_count = 0;
   flc_host flc_host_inst (
      .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .flash_addr(f_addr),
      .flash_dq_in(f_din), .flash_dq_out(f_dout), .flash_dq_oe(f_oe),
      .flash_ce_n(f_ce_n), .flash_oe_n(f_oe_n), .flash_we_n(f_we_n),
      .write_protect_pin(wp), .reset_powerdown_pin_n(rp_n));
   // Undriven data arrives inverted, so a missing enable garbles codes
   flc_flash_model flc_flash_model_inst (
      .addr(f_addr), .dq_drv(f_oe ? f_dout : ~f_dout), .ce_n(f_ce_n),
      .oe_n(f_oe_n), .we_n(f_we_n), .wp(wp), .rp_n(rp_n), .dq_in(f_din));
   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic test_done();
      if (fails == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      while (pready !== 1'b1) @(posedge ref_clk);
      rdv = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic op(input logic [3:0] c, input logic [21:0] a,
                     input logic [15:0] d = 16'h0000);
      apb(1'b1, OFS_ADDR, {10'h0, a});
      apb(1'b1, OFS_WDATA, {16'h0, d});
      apb(1'b1, OFS_CMD, {28'h0, c});
      wait_done();
   endtask
   task automatic wait_done();
      rdv = 32'h0;
      // A hang here is cut short by the watchdog
      while (rdv[STAT_BUSY] !== 1'b0 || rdv[STAT_DONE] !== 1'b1)
         apb(1'b0, OFS_STATUS, 32'h0);
   endtask
   // The host must leave the data bus to the flash during reads
   always @(posedge ref_clk) begin
      if (f_oe_n === 1'b0) begin
         chk({31'h0, f_oe}, 32'h0);
      end
   end
   task automatic res(input logic [15:0] e);
      chk({16'h0, rdv[31:16]}, {16'h0, e});
   endtask
   task automatic lk(input logic [21:0] a, input logic [1:0] e);
      op(OP_READ_LOCK, a);
      res({14'h0, e});
   endtask
   // ---------------------------------------------------------------
   // Clock, watchdog and tests
   // ---------------------------------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   initial begin
      repeat (60000) @(posedge ref_clk);
      fails++;
      test_done();
   end
   initial begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (4) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge ref_clk);
      apb(1'b1, OFS_CTRL, 32'h2);
      apb(1'b0, OFS_CTRL, 32'h0);
      chk(rdv, 32'h2);
      lk(BLK1, 2'h1);
      op(OP_UNLOCK, BLK1);
      lk(BLK1, 2'h0);
      op(OP_LOCK, BLK1);
      lk(BLK1, 2'h1);
      op(OP_LOCKDOWN, BLK2);
      lk(BLK2, 2'h3);
      op(OP_UNLOCK, BLK2);
      lk(BLK2, 2'h3);
      apb(1'b1, OFS_CTRL, 32'h3);
      op(OP_UNLOCK, BLK2);
      lk(BLK2, 2'h2);
      apb(1'b1, OFS_CTRL, 32'h2);
      lk(BLK2, 2'h3);
      op(OP_SUSPEND, BLK1);
      res(16'h00C0);
      op(OP_UNLOCK, BLK1);
      lk(BLK1, 2'h0);
      op(OP_RESUME, BLK1);
      op(OP_READ_STATUS, BLK1);
      res(16'h0080);
      op(OP_PR_PROG, PRU, 16'h1234);
      op(OP_PR_READ, PRU);
      res(16'h1234);
      op(OP_READ_ARRAY, PRU);
      op(OP_PROTECTION_LOCK_WORD, PRU);
      op(OP_PR_PROG, PRU, 16'h0000);
      op(OP_READ_STATUS, PRU);
      res(16'h0092);
      op(OP_PR_READ, PROTECTION_LOCK_WORD_ADDR);
      res(16'hFFFC);
      op(OP_PR_READ, PRU);
      res(16'h1234);
      apb(1'b1, OFS_CTRL, 32'h0);
      apb(1'b1, OFS_CTRL, 32'h2);
      lk(BLK2, 2'h1);
      op(OP_READ_STATUS, BLK2);
      res(16'h0080);
      apb(1'b1, OFS_CMD, {28'h0, OP_READ_STATUS});
      apb(1'b1, OFS_CMD, {28'h0, OP_UNLOCK});
      chk({31'h0, err}, 32'h1);
      wait_done();
      lk(BLK2, 2'h1);
      apb(1'b0, 8'h40, 32'h0);
      chk({err, rdv[30:0]}, 32'h80000000);
      apb(1'b1, OFS_CMD, 32'hB);
      chk({31'h0, err}, 32'h1);
      test_done();
   end
endmodule // flc_host_tb
